// [verilog/tmc_pkg.sv]
package tmc_pkg;

  // ==================================================================
  // Register addresses on the special-function bus
  localparam logic [7:0] ADDR_TCTRL   = 8'h88;
  localparam logic [7:0] ADDR_TMODE   = 8'h89;
  localparam logic [7:0] ADDR_T0_LOW  = 8'h8a;
  localparam logic [7:0] ADDR_T1_LOW  = 8'h8b;
  localparam logic [7:0] ADDR_T0_HIGH = 8'h8c;
  localparam logic [7:0] ADDR_T1_HIGH = 8'h8d;
  localparam logic [7:0] ADDR_CLKSEL  = 8'h8e;

  // ==================================================================
  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;

  // ==================================================================
  // Control register bit positions
  localparam int TC_T1_OVF = 7;
  localparam int TC_T1_RUN = 6;
  localparam int TC_T0_OVF = 5;
  localparam int TC_T0_RUN = 4;

  // Clock select register bit positions
  localparam int CS_T3_HIGH = 7;
  localparam int CS_T3_LOW  = 6;
  localparam int CS_T2_HIGH = 5;
  localparam int CS_T2_LOW  = 4;
  localparam int CS_T1_PICK = 3;
  localparam int CS_T0_PICK = 2;
  localparam int CS_DIV_HI  = 1;
  localparam int CS_DIV_LO  = 0;

  // ==================================================================
  // Operating modes and prescaler choices
  localparam logic [1:0] MODE_13BIT  = 2'h0;
  localparam logic [1:0] MODE_16BIT  = 2'h1;
  localparam logic [1:0] MODE_RELOAD = 2'h2;
  localparam logic [1:0] MODE_SPLIT  = 2'h3;

  localparam logic [1:0] DIV_SEL_12  = 2'h0;
  localparam logic [1:0] DIV_SEL_4   = 2'h1;
  localparam logic [1:0] DIV_SEL_48  = 2'h2;
  localparam logic [1:0] DIV_SEL_EXT = 2'h3;

  localparam int PRE_W = 6;
  localparam logic [PRE_W-1:0] DIV_12  = 6'h0c;
  localparam logic [PRE_W-1:0] DIV_4   = 6'h04;
  localparam logic [PRE_W-1:0] DIV_48  = 6'h30;
  localparam logic [PRE_W-1:0] DIV_EXT = 6'h08;

  localparam logic [4:0] LOW5_MAX = 5'h1f;
  localparam logic [7:0] BYTE_MAX = 8'hff;

  // ==================================================================
  // One nibble of the timer mode register
  typedef struct packed {
    logic       gate_enable;
    logic       count_mode;
    logic [1:0] mode;
  } tmc_mode_t;

  // Count state of one timer
  typedef struct packed {
    logic       ovf;
    logic [7:0] high;
    logic [7:0] low;
  } tmc_count_t;

endpackage

// [verilog/tmc_timer01.sv]
`timescale 1ns/1ps

module tmc_timer01 (
  // Clock and reset
  input  wire logic       clock_i,
  input  wire logic       rst_n_i,
  // Special-function register port
  input  wire logic [7:0] sfr_addr_i,
  input  wire logic       sfr_wr_i,
  input  wire logic       sfr_rd_i,
  input  wire logic [7:0] sfr_wdata_i,
  output logic      [7:0] sfr_rdata_o,
  // Pins from outside the clock domain
  input  wire logic       timer0_event_pin_i,
  input  wire logic       timer1_event_pin_i,
  input  wire logic       gate_input_0_i,
  input  wire logic       gate_input_1_i,
  input  wire logic       ext_clock_i,
  // Interrupt controller side
  input  wire logic       timer0_gate_enable_polarity_i,
  input  wire logic       gate1_polarity_i,
  input  wire logic       timer0_irq_enable_i,
  input  wire logic       timer1_irq_enable_i,
  input  wire logic       timer0_vector_ack_i,
  input  wire logic       timer1_vector_ack_i,
  output logic            timer0_irq_o,
  output logic            timer1_irq_o,
  // Overflow strobe for serial ports and converter trigger
  output logic            timer1_ovf_strobe_o,
  // Clock picks handed to timers 2 and 3
  output logic            timer3_high_clock_pick_o,
  output logic            timer3_low_clock_pick_o,
  output logic            timer2_high_clock_pick_o,
  output logic            timer2_low_clock_pick_o
);

  // ==================================================================
  // Registers
  logic [7:0] clksel_reg;
  logic [7:0] tctrl_reg;
  logic [7:0] tctrl_next;
  logic [7:0] tmode_reg;
  logic [7:0] t0_low_reg;
  logic [7:0] t0_low_next;
  logic [7:0] t0_high_reg;
  logic [7:0] t0_high_next;
  logic [7:0] t1_low_reg;
  logic [7:0] t1_low_next;
  logic [7:0] t1_high_reg;
  logic [7:0] t1_high_next;
  logic [7:0] rdata_next;
  logic [4:0] sync1_reg;
  logic [4:0] sync2_reg;
  logic [4:0] sync3_reg;
  logic [tmc_pkg::PRE_W-1:0] pre_cnt_reg;
  logic [tmc_pkg::PRE_W-1:0] pre_cnt_next;
  logic       ovf1_next;

  // ==================================================================
  // Synchronizers and edge detection
  // Third stage only keeps the previous level for edge detection
  // Reset low: a pin already high at release shows a rise, never a fall
  logic [4:0] pins_raw;
  assign pins_raw = {ext_clock_i, gate_input_1_i, gate_input_0_i,
                     timer1_event_pin_i, timer0_event_pin_i};

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sync1_reg <= 5'h00;
      sync2_reg <= 5'h00;
      sync3_reg <= 5'h00;
    end
    else
    begin
      sync1_reg <= pins_raw;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  wire ev0_fall = sync3_reg[0] & ~sync2_reg[0];
  wire ev1_fall = sync3_reg[1] & ~sync2_reg[1];
  wire timer0_gate_enable_lv = sync2_reg[2];
  wire gate1_lv = sync2_reg[3];
  wire ext_rise = sync2_reg[4] & ~sync3_reg[4];

  // ==================================================================
  // Prescaler, one tick per divided period
  wire [1:0] div_sel = clksel_reg[tmc_pkg::CS_DIV_HI:tmc_pkg::CS_DIV_LO];
  logic [tmc_pkg::PRE_W-1:0] div_val;
  assign div_val = (div_sel == tmc_pkg::DIV_SEL_12) ? tmc_pkg::DIV_12 :
                   (div_sel == tmc_pkg::DIV_SEL_4)  ? tmc_pkg::DIV_4  :
                   (div_sel == tmc_pkg::DIV_SEL_48) ? tmc_pkg::DIV_48 :
                                                      tmc_pkg::DIV_EXT;
  // External clock advances only on its synchronized rising edge
  wire pre_adv  = (div_sel != tmc_pkg::DIV_SEL_EXT) | ext_rise;
  // Count is kept across a select change, so the first period may be short
  wire pre_wrap = pre_adv & (pre_cnt_reg >= div_val - 6'h01);
  wire pre_tick = pre_wrap;
  assign pre_cnt_next = pre_wrap ? '0 :
                        pre_adv  ? pre_cnt_reg + 6'h01 : pre_cnt_reg;

  // ==================================================================
  // Timer clock and enable choices
  tmc_pkg::tmc_mode_t mode0;
  tmc_pkg::tmc_mode_t mode1;
  assign mode0 = tmc_pkg::tmc_mode_t'(tmode_reg[3:0]);
  assign mode1 = tmc_pkg::tmc_mode_t'(tmode_reg[7:4]);

  wire run0 = tctrl_reg[tmc_pkg::TC_T0_RUN];
  wire run1 = tctrl_reg[tmc_pkg::TC_T1_RUN];

  // Timer clocks, pick bit ignored while counting events
  wire clk0_tick = clksel_reg[tmc_pkg::CS_T0_PICK] | pre_tick;
  wire clk1_tick = clksel_reg[tmc_pkg::CS_T1_PICK] | pre_tick;
  wire tick0 = mode0.count_mode ? ev0_fall : clk0_tick;
  wire tick1 = mode1.count_mode ? ev1_fall : clk1_tick;

  wire timer0_gate_enable_ok = ~mode0.gate_enable | (timer0_gate_enable_lv == timer0_gate_enable_polarity_i);
  wire gate1_ok = ~mode1.gate_enable | (gate1_lv == gate1_polarity_i);
  wire en0 = run0 & timer0_gate_enable_ok;

  wire t0_split = (mode0.mode == tmc_pkg::MODE_SPLIT);
  // Mode 3 parks Timer1 whatever Timer0 is doing
  wire t1_halt  = (mode1.mode == tmc_pkg::MODE_SPLIT);
  // With Timer0 split, Timer1 runs from its mode alone and never counts edges
  wire t1_tick  = t0_split ? clk1_tick : tick1;
  wire en1      = ~t1_halt & (t0_split | (run1 & gate1_ok));

  // ==================================================================
  // Counting step shared by both timers in modes 0 to 2, and used by Timer0's low byte in mode 3
  function automatic tmc_pkg::tmc_count_t step(input logic [1:0] md,
                                               input logic [7:0] hi,
                                               input logic [7:0] lo);
    tmc_pkg::tmc_count_t r;
    logic [4:0] lo5;
    r   = '{ovf: 1'b0, high: hi, low: lo};
    lo5 = lo[4:0] + 5'h01;
    unique case (md)
      tmc_pkg::MODE_13BIT:
      begin
        r.low = {lo[7:5], lo5};
        if (lo[4:0] == tmc_pkg::LOW5_MAX)
        begin
          r.high = hi + 8'h01;
          r.ovf  = (hi == tmc_pkg::BYTE_MAX);
        end
      end
      tmc_pkg::MODE_16BIT:
      begin
        {r.high, r.low} = {hi, lo} + 16'h0001;
        r.ovf = ({hi, lo} == {tmc_pkg::BYTE_MAX, tmc_pkg::BYTE_MAX});
      end
      tmc_pkg::MODE_RELOAD:
      begin
        // High byte is the reload value and is left alone
        if (lo == tmc_pkg::BYTE_MAX)
        begin
          r.low = hi;
          r.ovf = 1'b1;
        end
        else
          r.low = lo + 8'h01;
      end
      tmc_pkg::MODE_SPLIT:
      begin
        r.low = lo + 8'h01;
        r.ovf = (lo == tmc_pkg::BYTE_MAX);
      end
    endcase
    return r;
  endfunction

  tmc_pkg::tmc_count_t t0_step;
  tmc_pkg::tmc_count_t t1_step;
  assign t0_step = step(mode0.mode, t0_high_reg, t0_low_reg);
  assign t1_step = step(mode1.mode, t1_high_reg, t1_low_reg);

  // Split-mode high byte: timer only, enabled by Timer1 run
  // It ignores the event pin and both gate inputs
  wire th0_adv = t0_split & run1 & clk0_tick;
  wire th0_ovf = th0_adv & (t0_high_reg == tmc_pkg::BYTE_MAX);

  wire t0_adv = en0 & tick0;
  wire t1_adv = en1 & t1_tick;
  wire ovf0   = t0_adv & t0_step.ovf;
  wire ovf1   = t1_adv & t1_step.ovf;

  // ==================================================================
  // Address decode shared by the write strobes and the read mux
  wire hit_ctrl = (sfr_addr_i == tmc_pkg::ADDR_TCTRL);
  wire hit_mode = (sfr_addr_i == tmc_pkg::ADDR_TMODE);
  wire hit_l0   = (sfr_addr_i == tmc_pkg::ADDR_T0_LOW);
  wire hit_h0   = (sfr_addr_i == tmc_pkg::ADDR_T0_HIGH);
  wire hit_l1   = (sfr_addr_i == tmc_pkg::ADDR_T1_LOW);
  wire hit_h1   = (sfr_addr_i == tmc_pkg::ADDR_T1_HIGH);
  wire hit_cs   = (sfr_addr_i == tmc_pkg::ADDR_CLKSEL);

  // ==================================================================
  // Register writes; software write wins over a count in the same cycle
  wire wr_ctrl = sfr_wr_i & hit_ctrl;
  wire wr_mode = sfr_wr_i & hit_mode;
  wire wr_l0   = sfr_wr_i & hit_l0;
  wire wr_h0   = sfr_wr_i & hit_h0;
  wire wr_l1   = sfr_wr_i & hit_l1;
  wire wr_h1   = sfr_wr_i & hit_h1;
  wire wr_cs   = sfr_wr_i & hit_cs;

  assign t0_low_next  = wr_l0  ? sfr_wdata_i :
                        t0_adv ? t0_step.low : t0_low_reg;
  assign t0_high_next = wr_h0   ? sfr_wdata_i :
                        t0_split ? (th0_adv ? t0_high_reg + 8'h01 : t0_high_reg) :
                        t0_adv  ? t0_step.high : t0_high_reg;
  assign t1_low_next  = wr_l1  ? sfr_wdata_i :
                        t1_adv ? t1_step.low : t1_low_reg;
  assign t1_high_next = wr_h1  ? sfr_wdata_i :
                        t1_adv ? t1_step.high : t1_high_reg;

  // Flag sources; Timer1's own overflow may not set its flag while split
  wire set_tf0 = ovf0;
  wire set_tf1 = t0_split ? th0_ovf : ovf1;
  // Low four control bits are plain storage here
  wire [7:0] ctrl_base = wr_ctrl ? sfr_wdata_i : tctrl_reg;

  always_comb
  begin
    tctrl_next = ctrl_base;
    if (timer0_vector_ack_i)
      tctrl_next[tmc_pkg::TC_T0_OVF] = 1'b0;
    if (timer1_vector_ack_i)
      tctrl_next[tmc_pkg::TC_T1_OVF] = 1'b0;
    // Set wins over any clear in the same cycle
    if (set_tf0)
      tctrl_next[tmc_pkg::TC_T0_OVF] = 1'b1;
    if (set_tf1)
      tctrl_next[tmc_pkg::TC_T1_OVF] = 1'b1;
  end

  // Strobe follows Timer1's own overflow in every mode
  // A reload value of all ones overflows and strobes on every tick
  assign ovf1_next = ovf1;

  // ==================================================================
  // Read decode; unmapped addresses read zero
  assign rdata_next =
    hit_ctrl ? tctrl_reg   :
    hit_mode ? tmode_reg   :
    hit_l0   ? t0_low_reg  :
    hit_h0   ? t0_high_reg :
    hit_l1   ? t1_low_reg  :
    hit_h1   ? t1_high_reg :
    hit_cs   ? clksel_reg  : 8'h00;

  // ==================================================================
  // State registers
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      clksel_reg  <= tmc_pkg::RST_BYTE;
      tctrl_reg   <= tmc_pkg::RST_BYTE;
      tmode_reg   <= tmc_pkg::RST_BYTE;
      t0_low_reg  <= tmc_pkg::RST_BYTE;
      t0_high_reg <= tmc_pkg::RST_BYTE;
      t1_low_reg  <= tmc_pkg::RST_BYTE;
      t1_high_reg <= tmc_pkg::RST_BYTE;
      pre_cnt_reg <= '0;
    end
    else
    begin
      if (wr_cs)
        clksel_reg <= sfr_wdata_i;
      if (wr_mode)
        tmode_reg <= sfr_wdata_i;
      tctrl_reg   <= tctrl_next;
      t0_low_reg  <= t0_low_next;
      t0_high_reg <= t0_high_next;
      t1_low_reg  <= t1_low_next;
      t1_high_reg <= t1_high_next;
      pre_cnt_reg <= pre_cnt_next;
    end
  end

  // ==================================================================
  // Registered outputs
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sfr_rdata_o              <= 8'h00;
      timer0_irq_o             <= 1'b0;
      timer1_irq_o             <= 1'b0;
      timer1_ovf_strobe_o      <= 1'b0;
      timer3_high_clock_pick_o <= 1'b0;
      timer3_low_clock_pick_o  <= 1'b0;
      timer2_high_clock_pick_o <= 1'b0;
      timer2_low_clock_pick_o  <= 1'b0;
    end
    else
    begin
      if (sfr_rd_i)
        sfr_rdata_o <= rdata_next;
      // Request tracks the next flag value, so both rise on one edge
      timer0_irq_o <= tctrl_next[tmc_pkg::TC_T0_OVF] & timer0_irq_enable_i;
      timer1_irq_o <= tctrl_next[tmc_pkg::TC_T1_OVF] & timer1_irq_enable_i;
      timer1_ovf_strobe_o      <= ovf1_next;
      timer3_high_clock_pick_o <= clksel_reg[tmc_pkg::CS_T3_HIGH];
      timer3_low_clock_pick_o  <= clksel_reg[tmc_pkg::CS_T3_LOW];
      timer2_high_clock_pick_o <= clksel_reg[tmc_pkg::CS_T2_HIGH];
      timer2_low_clock_pick_o  <= clksel_reg[tmc_pkg::CS_T2_LOW];
    end
  end

endmodule // tmc_timer01

// [verif/tmc_timer01_sva.sv]
`timescale 1ns/1ps

// ======================================
// Port checker for the timer block
module tmc_timer01_sva (
  // Clock and reset
  input wire logic       clock_i,
  input wire logic       rst_n_i,
  // Register port
  input wire logic [7:0] sfr_addr_i,
  input wire logic       sfr_wr_i,
  input wire logic       sfr_rd_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic [7:0] sfr_rdata_o,
  // Interrupt side
  input wire logic       timer0_irq_enable_i,
  input wire logic       timer1_irq_enable_i,
  input wire logic       timer0_vector_ack_i,
  input wire logic       timer1_vector_ack_i,
  input wire logic       timer0_irq_o,
  input wire logic       timer1_irq_o,
  input wire logic       timer1_ovf_strobe_o,
  // Clock picks
  input wire logic       timer3_high_clock_pick_o,
  input wire logic       timer3_low_clock_pick_o,
  input wire logic       timer2_high_clock_pick_o,
  input wire logic       timer2_low_clock_pick_o
);
  default clocking @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);

  wire logic sel_cs = (sfr_addr_i == tmc_pkg::ADDR_CLKSEL);

  a_irq0_needs_en:
    assert property (timer0_irq_o |-> $past(timer0_irq_enable_i)) else $error("irq0 unmasked");
  a_irq1_needs_en:
    assert property (timer1_irq_o |-> $past(timer1_irq_enable_i)) else $error("irq1 unmasked");
  a_ack0_clears:
    assert property (timer0_vector_ack_i |=> !timer0_irq_o) else $error("irq0 after ack");
  a_ack1_clears:
    assert property (timer1_vector_ack_i |=> !timer1_irq_o) else $error("irq1 after ack");
  a_strobe_one_cycle:
    assert property (timer1_ovf_strobe_o |=> !timer1_ovf_strobe_o) else $error("strobe long");
  a_rdata_holds:
    assert property (!sfr_rd_i |=> $stable(sfr_rdata_o)) else $error("read data moved");
  a_clksel_readback:
    assert property (sfr_wr_i && sel_cs ##1 !sfr_wr_i ##1 sfr_rd_i && sel_cs && !sfr_wr_i
      |=> sfr_rdata_o == $past(sfr_wdata_i, 3)) else $error("clock select readback");
  a_t3_pick_copy:
    assert property (sfr_wr_i && sel_cs |=> ##1 ({timer3_high_clock_pick_o,
      timer3_low_clock_pick_o, 6'h00} == ($past(sfr_wdata_i, 2) & 8'hc0)))
      else $error("timer3 picks");
  a_t2_pick_copy:
    assert property (sfr_wr_i && sel_cs |=> ##1 ({2'h0, timer2_high_clock_pick_o,
      timer2_low_clock_pick_o, 4'h0} == ($past(sfr_wdata_i, 2) & 8'h30)))
      else $error("timer2 picks");
endmodule // tmc_timer01_sva

// [verif/tmc_pin_model.sv]
`timescale 1ns/1ps

// ======================================
// Far-side pin driver
module tmc_pin_model (
  // Clock
  input  wire logic       clock_i,
  // Bits 0/1 event pins, 2 external clock, 3/4 gates
  output logic      [4:0] pins_o
);
  // Event pins idle high so a pulse is one falling edge
  logic [4:0] lvl = 5'h03;
  assign pins_o = lvl;

  // Hold below one clock would let the sampler miss a level
  task automatic pulses(input int p, input int n, input int hold);
    repeat (2 * n)
    begin
      repeat (hold) @(posedge clock_i);
      lvl[p] <= ~lvl[p];
    end
  endtask

  task automatic gate(input int g, input logic v);
    @(posedge clock_i);
    lvl[3 + g] <= v;
  endtask
endmodule // tmc_pin_model

// [verif/tb_timer01_counter_modes.sv]
`timescale 1ns/1ps

module tb_timer01_counter_modes;
  // ======================================
  // Signals
  logic        clock_i = 1'b0, rst_n_i = 1'b0;
  logic  [7:0] sfr_addr_i = 8'h00, sfr_wdata_i = 8'h00, sfr_rdata_o, d;
  logic        sfr_wr_i = 1'b0, sfr_rd_i = 1'b0;
  logic        timer0_gate_enable_polarity_i = 1'b1, gate1_polarity_i = 1'b1;
  logic        timer0_irq_enable_i = 1'b1, timer1_irq_enable_i = 1'b1;
  logic        timer0_vector_ack_i = 1'b0, timer1_vector_ack_i = 1'b0;
  logic        timer0_irq_o, timer1_irq_o, timer1_ovf_strobe_o;
  logic        timer3_high_clock_pick_o, timer3_low_clock_pick_o;
  logic        timer2_high_clock_pick_o, timer2_low_clock_pick_o;
  logic  [4:0] pins;
  wire         timer0_event_pin_i = pins[0], timer1_event_pin_i = pins[1];
  wire         ext_clock_i = pins[2], gate_input_0_i = pins[3], gate_input_1_i = pins[4];
  wire   [3:0] picks = {timer3_high_clock_pick_o, timer3_low_clock_pick_o,
                        timer2_high_clock_pick_o, timer2_low_clock_pick_o};
  logic [31:0] seed = 32'hcb7a;
  int          error_cnt = 0, n_compared = 0, k, n;
  int          dv[3] = '{12, 4, 48};

  always #20 clock_i = ~clock_i;

  tmc_timer01 i_dut (
    .clock_i, .rst_n_i, .sfr_addr_i, .sfr_wr_i, .sfr_rd_i, .sfr_wdata_i, .sfr_rdata_o,
    .timer0_event_pin_i, .timer1_event_pin_i, .gate_input_0_i, .gate_input_1_i, .ext_clock_i,
    .timer0_gate_enable_polarity_i, .gate1_polarity_i, .timer0_irq_enable_i, .timer1_irq_enable_i,
    .timer0_vector_ack_i, .timer1_vector_ack_i, .timer0_irq_o, .timer1_irq_o,
    .timer1_ovf_strobe_o, .timer3_high_clock_pick_o, .timer3_low_clock_pick_o,
    .timer2_high_clock_pick_o, .timer2_low_clock_pick_o
  );

  tmc_pin_model i_pins (.clock_i(clock_i), .pins_o(pins));

  // ======================================
  // Bus tasks and checks
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Reference model: ticks from a loaded value up to the first overflow
  function automatic int mdl_ovf_ticks(input int md, input int hi, input int lo);
    int span;
    int val;
    span = (md == 0) ? 8192 : (md == 1) ? 65536 : 256;
    val  = (md == 0) ? hi * 32 + lo % 32 : (md == 1) ? hi * 256 + lo : lo;
    return span - val;
  endfunction

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clock_i);
    sfr_addr_i  <= a;
    sfr_wdata_i <= v;
    sfr_wr_i    <= 1'b1;
    @(posedge clock_i);
    sfr_wr_i    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clock_i);
    sfr_addr_i <= a;
    sfr_rd_i   <= 1'b1;
    @(posedge clock_i);
    sfr_rd_i   <= 1'b0;
    #1 d = sfr_rdata_o;
  endtask

  task automatic load(input int t, input logic [7:0] hi, input logic [7:0] lo);
    wr(tmc_pkg::ADDR_T0_HIGH + 8'(t), hi);
    wr(tmc_pkg::ADDR_T0_LOW + 8'(t), lo);
  endtask

  // Count values are checked in windows: launch latency is not fixed
  task automatic chk(input logic [7:0] got, input int lo, input int hi);
    n_compared++;
    if ($isunknown(got) || got < lo || got > hi)
    begin
      $display("Error at %0t: got %0h, want %0h..%0h", $time, got, lo, hi);
      error_cnt++;
    end
  endtask

  task automatic wait_irq(input int t);
    k = 0;
    // Selector 2 watches the Timer1 overflow strobe instead of a request
    while ((t == 2 ? timer1_ovf_strobe_o : t ? timer1_irq_o : timer0_irq_o) !== 1'b1
           && k < 40)
    begin
      @(posedge clock_i);
      k++;
    end
  endtask

  task automatic conclude;
    $display("Compared %0d, errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    #400000;
    error_cnt++;
    conclude();
  end

  // ======================================
  // Scenarios
  initial
  begin
    repeat (10) @(posedge clock_i);
    rst_n_i <= 1'b1;
    rd(tmc_pkg::ADDR_CLKSEL);
    chk(d, 0, 0);
    rd(8'h90);
    chk(d, 0, 0);
    seed = lfsr(seed);
    wr(tmc_pkg::ADDR_CLKSEL, seed[7:0]);
    rd(tmc_pkg::ADDR_CLKSEL);
    chk(d, seed[7:0], seed[7:0]);
    chk(picks, seed[7:4], seed[7:4]);
    wr(tmc_pkg::ADDR_CLKSEL, 8'h0c);
    for (int m = 0; m < 3; m++)
    begin
      wr(tmc_pkg::ADDR_TMODE, 8'(m));
      load(0, (m == 2) ? 8'ha0 : 8'hff, 8'hfc);
      rd(tmc_pkg::ADDR_T0_LOW);
      chk(d, 'hfc, 'hfc);
      wr(tmc_pkg::ADDR_TCTRL, 8'h10);
      wait_irq(0);
      n = 1 + mdl_ovf_ticks(m, (m == 2) ? 'ha0 : 'hff, 'hfc);
      chk(8'(k), n, n);
      wr(tmc_pkg::ADDR_TCTRL, 8'h00);
      rd(tmc_pkg::ADDR_T0_HIGH);
      chk(d, (m == 2) ? 'ha0 : 0, (m == 2) ? 'ha0 : 0);
      rd(tmc_pkg::ADDR_T0_LOW);
      chk((m == 0) ? d & 8'h1f : d, (m == 2) ? 'ha0 : 0, (m == 2) ? 'ha4 : 4);
      chk(timer0_irq_o, 0, 0);
    end
    wr(tmc_pkg::ADDR_TMODE, 8'h10);
    timer1_irq_enable_i <= 1'b0;
    load(1, 8'hff, 8'hfc);
    wr(tmc_pkg::ADDR_TCTRL, 8'h40);
    repeat (20) @(posedge clock_i);
    chk(timer1_irq_o, 0, 0);
    rd(tmc_pkg::ADDR_TCTRL);
    chk(d & 8'hc0, 'hc0, 'hc0);
    {timer0_vector_ack_i, timer1_vector_ack_i} <= 2'b11;
    @(posedge clock_i);
    {timer0_vector_ack_i, timer1_vector_ack_i} <= 2'b00;
    rd(tmc_pkg::ADDR_TCTRL);
    chk(d & 8'h80, 0, 0);
    wr(tmc_pkg::ADDR_TCTRL, 8'h00);
    timer1_irq_enable_i <= 1'b1;
    wr(tmc_pkg::ADDR_TMODE, 8'h09);
    load(0, 8'h00, 8'h00);
    wr(tmc_pkg::ADDR_TCTRL, 8'h10);
    repeat (20) @(posedge clock_i);
    rd(tmc_pkg::ADDR_T0_LOW);
    chk(d, 0, 0);
    i_pins.gate(0, 1'b1);
    repeat (20) @(posedge clock_i);
    timer0_gate_enable_polarity_i <= 1'b0;
    repeat (4) @(posedge clock_i);
    rd(tmc_pkg::ADDR_T0_LOW);
    chk(d, 17, 26);
    k = d;
    repeat (10) @(posedge clock_i);
    rd(tmc_pkg::ADDR_T0_LOW);
    chk(d, k, k);
    wr(tmc_pkg::ADDR_TMODE, 8'h55);
    for (int t = 0; t < 2; t++)
    begin
      seed = lfsr(seed);
      n = seed[2:0] + 1;
      load(t, 8'h00, 8'h00);
      wr(tmc_pkg::ADDR_TCTRL, 8'h10 << (2 * t));
      i_pins.pulses(t, n, 2 + t);
      repeat (4) @(posedge clock_i);
      rd(tmc_pkg::ADDR_T0_LOW + 8'(t));
      chk(d, n, n);
    end
    wr(tmc_pkg::ADDR_TMODE, 8'h01);
    for (int s = 0; s < 4; s++)
    begin
      wr(tmc_pkg::ADDR_CLKSEL, 8'(s));
      load(0, 8'h00, 8'h00);
      wr(tmc_pkg::ADDR_TCTRL, 8'h10);
      if (s == 3)
        i_pins.pulses(2, 16, 2);
      else
        repeat (10 * dv[s]) @(posedge clock_i);
      wr(tmc_pkg::ADDR_TCTRL, 8'h00);
      rd(tmc_pkg::ADDR_T0_LOW);
      chk(d, (s == 3) ? 1 : 9, (s == 3) ? 2 : 11);
    end
    wr(tmc_pkg::ADDR_CLKSEL, 8'h04);
    wr(tmc_pkg::ADDR_TMODE, 8'h03);
    load(0, 8'hfc, 8'h00);
    load(1, 8'hff, 8'hff);
    wait_irq(2);
    chk(8'(k), 2, 13);
    @(posedge clock_i);
    chk(timer1_ovf_strobe_o, 0, 0);
    rd(tmc_pkg::ADDR_TCTRL);
    chk(d & 8'h80, 0, 0);
    wr(tmc_pkg::ADDR_TCTRL, 8'h40);
    wait_irq(1);
    chk(8'(k), 2, 8);
    rd(tmc_pkg::ADDR_T0_LOW);
    chk(d, 0, 0);
    wr(tmc_pkg::ADDR_TMODE, 8'h33);
    rd(tmc_pkg::ADDR_T1_LOW);
    k = d;
    repeat (30) @(posedge clock_i);
    rd(tmc_pkg::ADDR_T1_LOW);
    chk(d, k, k);
    conclude();
  end
endmodule // tb_timer01_counter_modes

bind tmc_timer01 tmc_timer01_sva i_sva (
  .clock_i, .rst_n_i, .sfr_addr_i, .sfr_wr_i, .sfr_rd_i, .sfr_wdata_i, .sfr_rdata_o,
  .timer0_irq_enable_i, .timer1_irq_enable_i, .timer0_vector_ack_i, .timer1_vector_ack_i,
  .timer0_irq_o, .timer1_irq_o, .timer1_ovf_strobe_o, .timer3_high_clock_pick_o,
  .timer3_low_clock_pick_o, .timer2_high_clock_pick_o, .timer2_low_clock_pick_o
);
